// File: rx_lane_slice.sv
// Receive lane slice: deserializer, word FIFO, output word, tap delay.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "lane_params.svh"
module rx_lane_slice (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Link to the fabric controller.
  lane_if.device_mp lnk,
  // Serial pad data and static configuration.
  input wire logic serial_input,
  input wire logic parallel_width_8,
  input wire lane_pkg::delay_mode_type delay_mode,
  input wire logic immediate_update
);
  import lane_pkg::*;

  // ---------------------------------------------------------------
  // Reset synchronisers.
  // ---------------------------------------------------------------
  logic [1:0] srst_r;
  logic [1:0] drst_r;
  logic lane_rst;
  logic dly_rst;

  always_ff @(posedge mclk or posedge lnk.slice_reset) begin
    if (lnk.slice_reset) begin
      srst_r <= `SYNC_ONES;
    end else begin
      srst_r <= {srst_r[0], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge lnk.delay_line_reset) begin
    if (lnk.delay_line_reset) begin
      drst_r <= `SYNC_ONES;
    end else begin
      drst_r <= {drst_r[0], 1'b0};
    end
  end

  assign lane_rst = srst_r[1];
  assign dly_rst = drst_r[1];

  // ---------------------------------------------------------------
  // Deserializer.
  // ---------------------------------------------------------------
  logic [`WORD_W-1:0] shift_r, shift_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [2:0] last_bit;
  logic push;
  logic [`WORD_W-1:0] push_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [`WORD_W-1:0] fifo_out_data;

  assign last_bit = parallel_width_8 ? 3'(`WORD_W - 1) : 3'(`NARROW_W - 1);

  always_comb begin
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    push = 1'b0;
    push_word = '0;
    if (fifo_in_ready) begin
      shift_nxt = {shift_r[`WORD_W-2:0], serial_input};
      if (bit_cnt_r == last_bit) begin
        push = 1'b1;
        bit_cnt_nxt = '0;
      end else begin
        bit_cnt_nxt = 3'(bit_cnt_r + 1'b1);
      end
    end
    if (parallel_width_8) begin
      push_word = shift_nxt;
    end else begin
      push_word[`NARROW_W-1:0] = shift_nxt[`NARROW_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge lane_rst) begin
    if (lane_rst) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end else if (!rstn) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end else begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  lane_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH)
  ) fifo_u (
    .mclk(mclk),
    .clear(lane_rst || !rstn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Output word register.
  // ---------------------------------------------------------------
  logic [`WORD_W-1:0] word_r, word_nxt;
  logic word_valid_r, word_valid_nxt;

  assign fifo_out_ready = !word_valid_r || lnk.word_ready;

  always_comb begin
    word_nxt = word_r;
    word_valid_nxt = word_valid_r;
    if (fifo_out_valid && fifo_out_ready) begin
      word_nxt = fifo_out_data;
      word_valid_nxt = 1'b1;
    end else if (lnk.word_ready) begin
      word_valid_nxt = 1'b0;
    end
    if (!parallel_width_8) begin
      word_nxt[`MIRROR_BIT] = serial_input;
    end
  end

  always_ff @(posedge mclk or posedge lane_rst) begin
    if (lane_rst) begin
      word_r <= '0;
      word_valid_r <= 1'b0;
    end else if (!rstn) begin
      word_r <= '0;
      word_valid_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      word_valid_r <= word_valid_nxt;
    end
  end

  assign lnk.word = word_r;
  assign lnk.word_valid = word_valid_r;

  // ---------------------------------------------------------------
  // Tap counter of the delay line.
  // ---------------------------------------------------------------
  logic [`TAP_W-1:0] tap_r, tap_nxt;
  logic [`TAP_W-1:0] tap_out_r;
  logic stepping;
  logic load_ok;

  assign stepping = delay_mode != DELAY_FIXED;
  assign load_ok = delay_mode == DELAY_STEPPING_LOAD && immediate_update;

  always_comb begin
    tap_nxt = tap_r;
    if (load_ok && lnk.load) begin
      tap_nxt = lnk.tap_value_in;
    end else if (stepping && lnk.step_enable) begin
      if (lnk.step_up) begin
        tap_nxt = `TAP_W'(tap_r + 1'b1);
      end else begin
        tap_nxt = `TAP_W'(tap_r - 1'b1);
      end
    end
  end

  always_ff @(posedge mclk or posedge dly_rst) begin
    if (dly_rst) begin
      tap_r <= `TAP_PRESET;
      tap_out_r <= `TAP_PRESET;
    end else if (!rstn) begin
      tap_r <= `TAP_PRESET;
      tap_out_r <= `TAP_PRESET;
    end else begin
      tap_r <= tap_nxt;
      tap_out_r <= tap_r;
    end
  end

  assign lnk.tap_value_out = tap_out_r;

  // ---------------------------------------------------------------
  // Delay ready indication.
  // ---------------------------------------------------------------
  logic [5:0] ready_cnt_r, ready_cnt_nxt;
  logic delay_ready_r, delay_ready_nxt;

  always_comb begin
    ready_cnt_nxt = ready_cnt_r;
    delay_ready_nxt = delay_ready_r;
    if (lane_rst) begin
      ready_cnt_nxt = '0;
      delay_ready_nxt = 1'b0;
    end else if (ready_cnt_r == `READY_CYC) begin
      delay_ready_nxt = 1'b1;
    end else begin
      ready_cnt_nxt = 6'(ready_cnt_r + 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge dly_rst) begin
    if (dly_rst) begin
      ready_cnt_r <= '0;
      delay_ready_r <= 1'b0;
    end else if (!rstn) begin
      ready_cnt_r <= '0;
      delay_ready_r <= 1'b0;
    end else begin
      ready_cnt_r <= ready_cnt_nxt;
      delay_ready_r <= delay_ready_nxt;
    end
  end

  assign lnk.delay_ready = delay_ready_r;
endmodule

// File: lane_params.svh
// Shared constants for the receive lane slice and its fabric controller.
`ifndef LANE_PARAMS_SVH
`define LANE_PARAMS_SVH
`define TAP_W 9
`define TAP_PRESET 9'h000
`define WORD_W 8
`define NARROW_W 4
`define MIRROR_BIT 5
`define FIFO_DEPTH 32
`define READY_CYC 6'h20
`define SETTLE_CYC 9'h003
`define SYNC_ONES 2'h3
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_VALUE 4'h4
`define REG_STATUS 4'h8
`define REG_WORD 4'hC
`define CTRL_LOAD 0
`define CTRL_STEP 1
`define CTRL_UP 2
`define CTRL_DRST 3
`define CTRL_SRST 4
`define CTRL_DRIFT 5
`define ST_BUSY 16
`define ST_READY 17
`define ST_VALID 18
`define WD_VALID 8
`endif

// File: lane_pkg.sv
// Types shared by the receive lane slice and its controller.
package lane_pkg;
  typedef enum logic [1:0] {
    DELAY_FIXED,
    DELAY_STEPPING,
    DELAY_STEPPING_LOAD
  } delay_mode_type;
  typedef enum logic [2:0] {
    H_IDLE,
    H_PRESENT,
    H_LOAD,
    H_STEP,
    H_SETTLE
  } host_state_type;
endpackage

// File: lane_if.sv
// Link between the receive lane slice and the fabric controller.
`timescale 1ns/1ps
`include "lane_params.svh"
interface lane_if;
  logic step_enable;
  logic step_up;
  logic load;
  logic [`TAP_W-1:0] tap_value_in;
  logic [`TAP_W-1:0] tap_value_out;
  logic delay_ready;
  logic [`WORD_W-1:0] word;
  logic word_valid;
  logic word_ready;
  logic slice_reset;
  logic delay_line_reset;
  logic drift_compensation_enable;
  modport device_mp (
    input step_enable, step_up, load, tap_value_in, word_ready,
    input slice_reset, delay_line_reset, drift_compensation_enable,
    output tap_value_out, delay_ready, word, word_valid
  );
  modport host_mp (
    output step_enable, step_up, load, tap_value_in, word_ready,
    output slice_reset, delay_line_reset, drift_compensation_enable,
    input tap_value_out, delay_ready, word, word_valid
  );
endinterface

// File: lane_fifo.sv
// Word FIFO between the deserializer and the output register.
`timescale 1ns/1ps
module lane_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic clear,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic do_wr, do_rd;

  assign in_ready = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data = mem[rd_ptr_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    wr_ptr_nxt = do_wr ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = do_rd ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    count_nxt = count_r;
    if (do_wr && !do_rd) begin
      count_nxt = (AW+1)'(count_r + 1'b1);
    end else if (do_rd && !do_wr) begin
      count_nxt = (AW+1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule

// File: lane_host.sv
// Fabric controller: Avalon-MM registers driving the lane slice link.
`timescale 1ns/1ps
`include "lane_params.svh"
module lane_host (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link to the lane slice.
  lane_if.host_mp lnk
);
  import lane_pkg::*;

  // ---------------------------------------------------------------
  // Bus slave.
  // ---------------------------------------------------------------
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req, accept, wr_ctrl;
  host_state_type state_r, state_nxt;
  logic [`TAP_W-1:0] value_r, value_nxt;

  assign req = avs_read || avs_write;
  assign accept = req && !wait_r;
  assign wr_ctrl = accept && avs_write && avs_address == `REG_CTRL;

  always_comb begin
    wait_nxt = !(req && wait_r);
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      rdata_nxt = '0;
      unique case (avs_address)
        `REG_VALUE: rdata_nxt[`TAP_W-1:0] = value_r;
        `REG_STATUS: begin
          rdata_nxt[`TAP_W-1:0] = lnk.tap_value_out;
          rdata_nxt[`ST_BUSY] = state_r != H_IDLE;
          rdata_nxt[`ST_READY] = lnk.delay_ready;
          rdata_nxt[`ST_VALID] = lnk.word_valid;
        end
        `REG_WORD: begin
          rdata_nxt[`WORD_W-1:0] = lnk.word;
          rdata_nxt[`WD_VALID] = lnk.word_valid;
          if (!lnk.delay_ready) begin
            rdata_nxt[`MIRROR_BIT] = 1'b0;
          end
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control registers and command sequencer.
  // ---------------------------------------------------------------
  logic [`TAP_W-1:0] cnt_r, cnt_nxt;
  logic [`TAP_W-1:0] tapv_r, tapv_nxt;
  logic load_r, load_nxt, step_r, step_nxt, up_r, up_nxt;
  logic srst_r, srst_nxt, drst_r, drst_nxt;
  logic drift_cfg_r, drift_cfg_nxt, drift_r, drift_nxt;
  logic pop_r, pop_nxt;

  always_comb begin
    value_nxt = value_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    tapv_nxt = tapv_r;
    load_nxt = 1'b0;
    step_nxt = step_r;
    up_nxt = up_r;
    srst_nxt = srst_r;
    drst_nxt = drst_r;
    drift_cfg_nxt = drift_cfg_r;
    pop_nxt = accept && avs_read && avs_address == `REG_WORD
              && rdata_r[`WD_VALID];
    if (accept && avs_write && avs_address == `REG_VALUE) begin
      value_nxt = avs_writedata[`TAP_W-1:0];
    end
    unique case (state_r)
      H_IDLE: begin
        if (wr_ctrl) begin
          srst_nxt = avs_writedata[`CTRL_SRST];
          drst_nxt = avs_writedata[`CTRL_DRST];
          drift_cfg_nxt = avs_writedata[`CTRL_DRIFT];
          up_nxt = avs_writedata[`CTRL_UP];
          if (avs_writedata[`CTRL_LOAD]) begin
            tapv_nxt = value_r;
            state_nxt = H_PRESENT;
          end else if (avs_writedata[`CTRL_STEP] && value_r != '0) begin
            cnt_nxt = value_r;
            step_nxt = 1'b1;
            state_nxt = H_STEP;
          end
        end
      end
      H_PRESENT: begin
        load_nxt = 1'b1;
        state_nxt = H_LOAD;
      end
      H_LOAD: begin
        cnt_nxt = `SETTLE_CYC;
        state_nxt = H_SETTLE;
      end
      H_STEP: begin
        cnt_nxt = `TAP_W'(cnt_r - 1'b1);
        if (cnt_r == `TAP_W'(1)) begin
          step_nxt = 1'b0;
          cnt_nxt = `SETTLE_CYC;
          state_nxt = H_SETTLE;
        end
      end
      H_SETTLE: begin
        cnt_nxt = `TAP_W'(cnt_r - 1'b1);
        if (cnt_r == `TAP_W'(1)) begin
          state_nxt = H_IDLE;
        end
      end
    endcase
    drift_nxt = drift_cfg_nxt && state_nxt == H_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      state_r <= H_IDLE;
      value_r <= '0;
      cnt_r <= '0;
      tapv_r <= '0;
      load_r <= 1'b0;
      step_r <= 1'b0;
      up_r <= 1'b0;
      srst_r <= 1'b0;
      drst_r <= 1'b0;
      drift_cfg_r <= 1'b0;
      drift_r <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      value_r <= value_nxt;
      cnt_r <= cnt_nxt;
      tapv_r <= tapv_nxt;
      load_r <= load_nxt;
      step_r <= step_nxt;
      up_r <= up_nxt;
      srst_r <= srst_nxt;
      drst_r <= drst_nxt;
      drift_cfg_r <= drift_cfg_nxt;
      drift_r <= drift_nxt;
      pop_r <= pop_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign lnk.step_enable = step_r;
  assign lnk.step_up = up_r;
  assign lnk.load = load_r;
  assign lnk.tap_value_in = tapv_r;
  assign lnk.word_ready = pop_r;
  assign lnk.slice_reset = srst_r;
  assign lnk.delay_line_reset = drst_r;
  assign lnk.drift_compensation_enable = drift_r;
endmodule

// File: lane_monitor.sv
// Assertions on the link between the lane slice and its controller.
`timescale 1ns/1ps
`include "lane_params.svh"
module lane_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Link signals.
  input wire logic step_enable,
  input wire logic step_up,
  input wire logic load,
  input wire logic [`TAP_W-1:0] tap_value_in,
  input wire logic [`TAP_W-1:0] tap_value_out,
  input wire logic delay_ready,
  input wire logic [`WORD_W-1:0] word,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic slice_reset,
  input wire logic delay_line_reset,
  input wire logic drift_compensation_enable,
  // Static configuration.
  input wire lane_pkg::delay_mode_type delay_mode,
  input wire logic immediate_update,
  input wire logic parallel_width_8
);
  import lane_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence quiet;
    !delay_line_reset && !$past(delay_line_reset) &&
    !$past(delay_line_reset, 2) && !$past(delay_line_reset, 3);
  endsequence
  sequence stepped(logic up);
    (step_enable && step_up == up && !load && delay_mode != DELAY_FIXED)
    ##0 quiet;
  endsequence
  sequence loaded;
    (load && delay_mode == DELAY_STEPPING_LOAD && immediate_update) ##0 quiet;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_word_reset_zero: assert property (
    slice_reset |-> word == 8'h00 && !word_valid)
    else $error("word not cleared by slice reset");
  a_narrow_unused: assert property (
    !parallel_width_8 |-> word[7:6] == 2'h0 && !word[4])
    else $error("unused narrow bits set");
  a_drst_preset: assert property (
    delay_line_reset |-> tap_value_out == `TAP_PRESET)
    else $error("tap not at preset under delay reset");
  a_ready_drop: assert property (
    delay_line_reset || slice_reset |=> !delay_ready)
    else $error("ready kept during reset");
  a_step_up: assert property (
    stepped(1'b1) |=> ##1 tap_value_out == $past(tap_value_out) + 9'h001)
    else $error("step up wrong");
  a_step_down: assert property (
    stepped(1'b0) |=> ##1 tap_value_out == $past(tap_value_out) - 9'h001)
    else $error("step down wrong");
  a_tap_hold: assert property (
    ((!step_enable || delay_mode == DELAY_FIXED) && !(load &&
    delay_mode == DELAY_STEPPING_LOAD && immediate_update)) ##0 quiet
    |=> ##1 (delay_line_reset || $stable(tap_value_out)))
    else $error("tap moved without cause");
  a_load_copy: assert property (
    loaded |-> ##2 tap_value_out == $past(tap_value_in, 2))
    else $error("load value not taken");
  a_load_quiet: assert property (
    load |-> !step_enable && !drift_compensation_enable)
    else $error("step or drift during load");
  a_value_early: assert property (
    load |-> $stable(tap_value_in))
    else $error("tap value changed at load");
  a_pop_pulse: assert property (
    word_ready |=> !word_ready)
    else $error("pop longer than one cycle");
  a_word_holds: assert property (
    word_valid && !word_ready && !slice_reset |=> (slice_reset ||
    $stable(word[3:0])))
    else $error("unread word changed");
  a_value_drift: assert property (
    $changed(tap_value_in) |-> !drift_compensation_enable)
    else $error("tap value changed with drift on");
endmodule

// File: test_rx_lane_delay_and_deser_output.sv
// Testbench joining the lane slice and its controller over the link.
`timescale 1ns/1ps
`include "lane_params.svh"
module test_rx_lane_delay_and_deser_output;
  import lane_pkg::*;
  logic mclk, rstn, serial_input, parallel_width_8, immediate_update;
  delay_mode_type delay_mode;
  logic [`ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, up, lvl;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0] tap, n, ex;
  int errors, n_checks, seed;
  lane_if lnk();
  rx_lane_slice rx_lane_slice_i (.mclk(mclk), .rstn(rstn), .lnk(lnk),
    .serial_input(serial_input), .parallel_width_8(parallel_width_8),
    .delay_mode(delay_mode), .immediate_update(immediate_update));
  lane_host lane_host_i (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lnk(lnk));
  lane_monitor lane_monitor_i (.mclk(mclk), .rstn(rstn),
    .step_enable(lnk.step_enable), .step_up(lnk.step_up), .load(lnk.load),
    .tap_value_in(lnk.tap_value_in), .tap_value_out(lnk.tap_value_out),
    .delay_ready(lnk.delay_ready), .word(lnk.word),
    .word_valid(lnk.word_valid), .word_ready(lnk.word_ready),
    .slice_reset(lnk.slice_reset), .delay_line_reset(lnk.delay_line_reset),
    .drift_compensation_enable(lnk.drift_compensation_enable),
    .delay_mode(delay_mode), .immediate_update(immediate_update),
    .parallel_width_8(parallel_width_8));
  // ----------------------------------------
  // Tasks and functions
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, `REG_STATUS, 32'h0);
      k++;
    end while (rd[b] !== v && k < 60);
    chk(rd[b], v, "status poll");
  endtask
  task automatic cmd(input logic [8:0] v, input logic [31:0] c);
    bus(1'b1, `REG_VALUE, {23'h0, v});
    bus(1'b1, `REG_CTRL, c);
    poll(`ST_BUSY, 1'b0);
    bus(1'b0, `REG_STATUS, 32'h0);
  endtask
  function automatic logic [8:0] moved(logic [8:0] t, logic [8:0] k,
    logic u);
    return u ? t + k : t - k;
  endfunction
  function automatic logic [31:0] wexp(logic l, logic w);
    return {23'h0, 1'b1, w ? {8{l}} : {2'h0, l, 1'b0, {4{l}}}};
  endfunction
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    end_sim();
  end
  initial begin
    seed = 3019;
    errors = 0;
    n_checks = 0;
    rstn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    serial_input = 1'b0;
    parallel_width_8 = 1'b1;
    immediate_update = 1'b1;
    delay_mode = DELAY_STEPPING_LOAD;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(rd & 32'h1FF, {23'h0, `TAP_PRESET}, "preset tap");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      tap = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : 9'($random(seed));
      n = (i < 2) ? 9'h001 : 9'h001 + 9'($random(seed) & 32'h3F);
      up = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
      cmd(tap, up ? 32'h21 : 32'h1);
      chk(rd & 32'h1FF, {23'h0, tap}, "load");
      cmd(n, up ? 32'h6 : 32'h2);
      chk(rd & 32'h1FF, {23'h0, moved(tap, n, up)}, "step");
    end
    $display("test load_step done");
    for (int m = 0; m < 4; m++) begin
      delay_mode <= (m == 0) ? DELAY_FIXED :
        (m == 1) ? DELAY_STEPPING : DELAY_STEPPING_LOAD;
      immediate_update <= (m != 2);
      bus(1'b0, `REG_STATUS, 32'h0);
      ex = (m == 3) ? 9'h0A5 : rd[8:0];
      cmd(9'h0A5, 32'h1);
      chk(rd & 32'h1FF, {23'h0, ex}, "mode load");
      ex = (m == 0) ? ex : moved(ex, 9'h003, 1'b1);
      cmd(9'h003, 32'h6);
      chk(rd & 32'h1FF, {23'h0, ex}, "mode step");
    end
    $display("test modes done");
    bus(1'b1, `REG_CTRL, 32'h8);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(rd & 32'h201FF, 32'h0, "delay reset");
    bus(1'b1, `REG_CTRL, 32'h0);
    poll(`ST_READY, 1'b1);
    $display("test delay_reset done");
    for (int t = 0; t < 4; t++) begin
      lvl = 1'($random(seed));
      bus(1'b1, `REG_CTRL, 32'h10);
      parallel_width_8 <= t[0];
      serial_input <= lvl;
      bus(1'b0, `REG_WORD, 32'h0);
      chk(rd & 32'h1FF, 32'h0, "word in reset");
      bus(1'b1, `REG_CTRL, 32'h0);
      poll(`ST_READY, 1'b1);
      repeat (300) @(posedge mclk);
      for (int k = 0; k < 36; k++) begin
        bus(1'b0, `REG_WORD, 32'h0);
        if (k > 1) begin
          chk(rd & 32'h1FF, wexp(lvl, t[0]), "word");
        end
      end
    end
    $display("test words done");
    end_sim();
  end
endmodule
